// ---- rtl/adc_out_regs.vh ----
// Constants for the sample output control block of a pipelined converter.
// Assumes inclusion by the design file; holds definitions only.
// What this block does
// - Take a new input sample on every rising edge of the sample clock.
// - Present each sample's result on the outputs five clock cycles after capture.
// - Power-down low, enable low: convert normally and drive data and flag.
// - Power-down low, enable high: keep converting, data and flag lines released.
// - Power-down high, enable low: nap mode, all outputs released.
// - Power-down high, enable high: sleep mode, all outputs released.
// - Format pin levels pick offset binary or two's complement and stabiliser state.
// - Output a 12-bit word on twelve lines, top line is the MSB.
// - Raise the range flag when the sample overflowed or underflowed the range.
`ifndef ADC_OUT_REGS_VH
`define ADC_OUT_REGS_VH
`define SAMPLE_WIDTH      12
`define PIPE_LATENCY      5
`define FIFO_DEPTH        8
`define FIFO_AW           3
`define FMT_OB_STAB_OFF   2'h0
`define FMT_OB_STAB_ON    2'h1
`define FMT_TC_STAB_OFF   2'h2
`define FMT_TC_STAB_ON    2'h3
`define FMT_TWOS_BIT      1
`define FMT_STAB_BIT      0
`define MODE_LVL_GND      2'h0
`define MODE_LVL_THIRD    2'h1
`define MODE_LVL_TWOTHIRD 2'h2
`define MODE_LVL_FULL     2'h3
`define PWR_NORMAL        2'h0
`define PWR_HIGHZ         2'h1
`define PWR_NAP           2'h2
`define PWR_SLEEP         2'h3
`endif

// ---- rtl/adc_sample_output_control.v ----
// Sample FIFO and pipeline output control for a 12-bit sampling converter.
// Assumes all inputs synchronous to clk; the outer wrapper resolves the enables to pins.
`timescale 1ns/1ps
`include "adc_out_regs.vh"

module sample_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            empty;
  wire            full;
  wire            pop;
  wire            push;
  assign empty    = (wr_q == rd_q);
  assign full     = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign in_ready = !full;
  assign pop      = !empty && (!out_valid || out_ready);
  assign push     = in_valid && !full;
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_q      <= {(AW+1){1'b0}};
      rd_q      <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rd_q[AW-1:0]];
        out_valid <= 1'b1;
        rd_q      <= rd_q + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

module power_mode_decode (
  input  wire power_down_select,
  input  wire output_enable_n,
  output wire converting,
  output wire drive_en,
  output wire nap_mode,
  output wire sleep_mode
);
  wire [1:0] pwr;
  // Only the power-down pin stops conversion; the enable alone merely releases the lines.
  assign pwr        = {power_down_select, output_enable_n};
  assign converting = !power_down_select;
  assign drive_en   = (pwr == `PWR_NORMAL);
  assign nap_mode   = (pwr == `PWR_NAP);
  assign sleep_mode = (pwr == `PWR_SLEEP);
endmodule

module format_select #(
  parameter SW = `SAMPLE_WIDTH
) (
  input  wire [1:0]    format_level,
  input  wire [SW-1:0] raw_code,
  output wire          twos_complement,
  output wire          stabiliser_on,
  output wire [SW-1:0] code_fmt
);
  wire [1:0] mode_bits;

  // Upper bit picks two's complement, lower bit the duty-cycle stabiliser.
  function [1:0] mode_decode;
    input [1:0] lvl;
    begin
      case (lvl)
        `MODE_LVL_GND:      mode_decode = `FMT_OB_STAB_OFF;
        `MODE_LVL_THIRD:    mode_decode = `FMT_OB_STAB_ON;
        `MODE_LVL_TWOTHIRD: mode_decode = `FMT_TC_STAB_ON;
        `MODE_LVL_FULL:     mode_decode = `FMT_TC_STAB_OFF;
        default:            mode_decode = `FMT_OB_STAB_OFF;
      endcase
    end
  endfunction

  assign mode_bits       = mode_decode(format_level);
  assign twos_complement = mode_bits[`FMT_TWOS_BIT];
  assign stabiliser_on   = mode_bits[`FMT_STAB_BIT];
  // Format is applied at capture, so a change mid-run reaches only new samples.
  // Inverting the MSB re-centres the code so mid-scale becomes zero.
  assign code_fmt = {raw_code[SW-1] ^ twos_complement, raw_code[SW-2:0]};
endmodule

module pipe_stage #(
  parameter W = 13
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  input  wire         keep,
  output reg  [W-1:0] out_data,
  output reg          out_valid
);
  // A stage always moves its word on; only the valid bit is cleared by power-down,
  // so the data path needs no enable.
  always @(posedge clk) begin
    if (!rst_n) begin
      out_data  <= {W{1'b0}};
      out_valid <= 1'b0;
    end else begin
      out_data  <= in_data;
      out_valid <= in_valid && keep;
    end
  end
endmodule

module capture_port #(
  parameter DW    = 13,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [DW-1:0] in_data,
  input  wire          in_valid,
  input  wire          drive_en,
  input  wire          capture_ready,
  output wire          sample_valid,
  output wire          overrun
);
  wire          head_valid;
  wire          space;

  // Samples are dropped, not stalled, when the capture side lags: a converter cannot wait.
  assign overrun      = in_valid && !space;
  // Released lines carry nothing, so the capture side is told no word stands there.
  assign sample_valid = head_valid && drive_en;

  sample_fifo #(
    .WIDTH (DW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) sample_fifo_i (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (in_data),
    .in_valid  (in_valid),
    .in_ready  (space),
    .out_data  (),
    .out_valid (head_valid),
    .out_ready (capture_ready)
  );
endmodule

module sample_bundle #(
  parameter SW = `SAMPLE_WIDTH
) (
  input  wire [SW-1:0] code_fmt,
  input  wire          raw_over,
  input  wire          raw_under,
  output wire [SW:0]   bundle
);
  // The flag rides in the top bit so it cannot slip against its word.
  assign bundle = {raw_over | raw_under, code_fmt};
endmodule

module adc_sample_output_control #(
  parameter SW      = `SAMPLE_WIDTH,
  parameter LATENCY = `PIPE_LATENCY
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [SW-1:0] raw_code,
  input  wire          raw_over,
  input  wire          raw_under,
  input  wire          power_down_select,
  input  wire          output_enable_n,
  input  wire [1:0]    format_level,
  input  wire          capture_ready,
  output reg  [SW-1:0] sample_word_lines,
  output reg           range_exceeded_flag,
  output wire          data_oe,
  output wire          flag_oe,
  output wire          sample_valid,
  output wire          twos_complement,
  output wire          stabiliser_on,
  output wire          nap_mode,
  output wire          sleep_mode,
  output wire          overrun
);
  localparam DW = SW + 1;

  wire [DW*LATENCY-1:0] stage_data;
  wire [LATENCY-1:0]    stage_valid;
  wire [DW-1:0]         head_word;
  wire [DW-1:0]         tail_data;
  wire                  tail_valid;
  wire                  converting;
  wire                  drive_en;
  wire [SW-1:0]         code_fmt;
  genvar                i;

  power_mode_decode power_mode_decode_i (
    .power_down_select (power_down_select),
    .output_enable_n   (output_enable_n),
    .converting        (converting),
    .drive_en          (drive_en),
    .nap_mode          (nap_mode),
    .sleep_mode        (sleep_mode)
  );

  assign data_oe = drive_en;
  assign flag_oe = drive_en;

  format_select #(
    .SW (SW)
  ) format_select_i (
    .format_level    (format_level),
    .raw_code        (raw_code),
    .twos_complement (twos_complement),
    .stabiliser_on   (stabiliser_on),
    .code_fmt        (code_fmt)
  );

  sample_bundle #(
    .SW (SW)
  ) sample_bundle_i (
    .code_fmt  (code_fmt),
    .raw_over  (raw_over),
    .raw_under (raw_under),
    .bundle    (head_word)
  );

  // A fresh sample enters the first stage on every rising edge while converting.
  generate
    for (i = 0; i < LATENCY; i = i + 1) begin : g_pipe
      if (i == 0) begin : g_head
        pipe_stage #(
          .W (DW)
        ) pipe_stage_i (
          .clk       (clk),
          .rst_n     (rst_n),
          .in_data   (head_word),
          .in_valid  (1'b1),
          .keep      (converting),
          .out_data  (stage_data[DW-1:0]),
          .out_valid (stage_valid[0])
        );
      end else begin : g_body
        pipe_stage #(
          .W (DW)
        ) pipe_stage_i (
          .clk       (clk),
          .rst_n     (rst_n),
          .in_data   (stage_data[(i-1)*DW +: DW]),
          .in_valid  (stage_valid[i-1]),
          .keep      (converting),
          .out_data  (stage_data[i*DW +: DW]),
          .out_valid (stage_valid[i])
        );
      end
    end
  endgenerate

  assign tail_data  = stage_data[(LATENCY-1)*DW +: DW];
  assign tail_valid = stage_valid[LATENCY-1];

  // The output register follows the last stage, which puts the result five edges out.
  // Power-down clears only the valid bits, so the lines keep the last word.
  always @(posedge clk) begin
    if (!rst_n) begin
      sample_word_lines   <= {SW{1'b0}};
      range_exceeded_flag <= 1'b0;
    end else if (tail_valid) begin
      sample_word_lines   <= tail_data[SW-1:0];
      range_exceeded_flag <= tail_data[SW];
    end
  end

  // Only the handshake side is buffered; the word lines never wait for the capture logic.
  capture_port #(
    .DW    (DW),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) capture_port_i (
    .clk           (clk),
    .rst_n         (rst_n),
    .in_data       (tail_data),
    .in_valid      (tail_valid),
    .drive_en      (drive_en),
    .capture_ready (capture_ready),
    .sample_valid  (sample_valid),
    .overrun       (overrun)
  );
endmodule

// ---- test/adc_out_sva.sv ----
// Port checker for the sample output control block.
// Assumes a bind onto adc_sample_output_control with 12-bit words.
`timescale 1ns/1ps
module adc_out_sva (
  input wire        clk, rst_n, raw_over, raw_under, power_down_select, output_enable_n,
  input wire [11:0] raw_code, sample_word_lines,
  input wire [1:0]  format_level,
  input wire        range_exceeded_flag, data_oe, flag_oe, sample_valid, twos_complement,
  input wire        stabiliser_on, nap_mode, sleep_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Power-down drops samples in flight, so only unbroken runs are judged.
  sequence conv_run; !power_down_select [*7]; endsequence
  word_delay_a: assert property (conv_run |-> sample_word_lines ==
    ($past(raw_code, 6) ^ {$past(format_level[1], 6), 11'h000})) else $error("word");
  flag_delay_a: assert property (conv_run |-> range_exceeded_flag ==
    ($past(raw_over, 6) | $past(raw_under, 6))) else $error("flag");
  drive_on_a: assert property (data_oe == (!power_down_select && !output_enable_n)
    && flag_oe == data_oe) else $error("oe");
  nap_on_a: assert property (nap_mode == (power_down_select && !output_enable_n))
    else $error("nap");
  sleep_on_a: assert property (sleep_mode == (power_down_select && output_enable_n))
    else $error("sleep");
  twos_sel_a: assert property (twos_complement == format_level[1]) else $error("fmt");
  stab_sel_a: assert property (stabiliser_on == ^format_level) else $error("stab");
  valid_gate_a: assert property (sample_valid |-> data_oe) else $error("valid");
endmodule
bind adc_sample_output_control adc_out_sva adc_out_sva_i (.*);

// ---- test/capture_model.sv ----
// Capture logic model on the far side of the sample lines.
// Assumes the converter clock is shared.
`timescale 1ns/1ps
module capture_model (
  input  wire         clk,
  input  wire         stall,
  input  wire  [11:0] sample_word_lines,
  input  wire         data_oe,
  output logic        capture_ready = 1'b1,
  output logic [11:0] bus_q = 12'h000
);
  // Released lines float, so a changing pattern is shown instead of the last word.
  always @(posedge clk) begin
    capture_ready <= !stall;
    bus_q <= data_oe ? sample_word_lines : ~bus_q;
  end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the sample output control block.
// Assumes the checker and capture model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb;
  logic clk = 0, rst_n = 0, raw_over = 0, raw_under = 0, power_down_select = 0;
  logic output_enable_n = 0, stall = 0, capture_ready, range_exceeded_flag, data_oe, flag_oe;
  logic sample_valid, twos_complement, stabiliser_on, nap_mode, sleep_mode, overrun, seen;
  logic [11:0] raw_code = 12'h000, sample_word_lines, bus_q;
  logic [1:0]  format_level = 2'h0;
  logic [12:0] hist [0:63];
  int          num_errors = 0, checks = 0;
  wire  [12:0] out_w = {range_exceeded_flag, sample_word_lines};
  initial forever #2.5 clk = ~clk;
  adc_sample_output_control adc_sample_output_control_i (.*);
  capture_model capture_model_i (.*);
  task automatic stream(input logic [1:0] f, input logic en_n, input int n);
    seen = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      format_level <= f;
      output_enable_n <= en_n;
      hist[i] = {i[0] | i[2], 12'h09b7 * i[11:0]};
      raw_code <= hist[i][11:0];
      raw_over <= i[0];
      raw_under <= i[2];
      #1 seen |= overrun;
      if (i > 5) `CHK("word", (hist[i-6] ^ {1'b0, f[1], 11'h000}), out_w)
      if (i > 6 && !en_n) `CHK("bus", (hist[i-7][11:0] ^ {f[1], 11'h000}), bus_q)
    end
    `CHK("mode", ({!en_n, !en_n, f[1], ^f}), ({data_oe, sample_valid, twos_complement, stabiliser_on}))
    $display("stream %0d %0b done", f, en_n);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    stream(2'h0, 0, 16);
    stream(2'h1, 1, 10);
    stream(2'h2, 0, 10);
    stall <= 1;
    stream(2'h3, 0, 24);
    stall <= 0;
    `CHK("overrun", 1'b1, seen)
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      {power_down_select, output_enable_n} <= m[1:0];
      repeat (2) @(posedge clk);
      #1 `CHK("pins", ({m == 0, m == 2, m == 3}), ({flag_oe, nap_mode, sleep_mode}))
    end
    finish_test;
  end
  initial begin
    #5000;
    num_errors++;
    finish_test;
  end
endmodule
